// >>> umff_pkg.sv
// Package for the upstream frame fragmenter: register map, field layout, timing.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register slave.
package umff_pkg;
   // ****************************************************************
   // Register byte offsets
   // ****************************************************************
   localparam logic [7:0] UMFF_CTRL_OFF    = 8'h00; // enable bits
   localparam logic [7:0] UMFF_FRAME_OFF   = 8'h04; // new frame length, go
   localparam logic [7:0] UMFF_GRANT_OFF   = 8'h08; // grant map entry
   localparam logic [7:0] UMFF_FRAG_OFF    = 8'h0c; // last fragment descriptor
   localparam logic [7:0] UMFF_REQ_OFF     = 8'h10; // last request issued
   localparam logic [7:0] UMFF_STATE_OFF   = 8'h14; // remainder and sequence
   localparam logic [7:0] UMFF_IRQ_STS_OFF = 8'h18; // sticky events, read clears
   localparam logic [7:0] UMFF_IRQ_MSK_OFF = 8'h1c; // interrupt mask
   localparam logic [7:0] UMFF_RETRY_OFF   = 8'h20; // retry threshold
   localparam logic [7:0] UMFF_ACKT_OFF    = 8'h24; // ack time in us
   localparam logic [7:0] UMFF_POH_OFF     = 8'h28; // physical layer overhead bytes
   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int UMFF_CTRL_FRAG_EN  = 0;  // fragmentation enabled for flow
   localparam int UMFF_FRAME_GO      = 31; // write 1 with length to queue frame
   localparam int UMFF_FRAME_IMM     = 30; // frame sent in request/data region
   localparam int UMFF_GRANT_PEND    = 31; // grant pending element (zero length)
   localparam int UMFF_GRANT_MORE    = 30; // further grants queued in map
   localparam int UMFF_LEN_W         = 16;
   localparam int UMFF_SEQ_W         = 4;
   // Interrupt event bits
   localparam int UMFF_EV_FRAG    = 0;
   localparam int UMFF_EV_DONE    = 1;
   localparam int UMFF_EV_RETRY   = 2;
   localparam int UMFF_EV_DISCARD = 3;
   localparam int UMFF_EV_W       = 4;
   // ****************************************************************
   // Reset values and constants
   // ****************************************************************
   localparam logic [15:0] UMFF_FRAG_OVH      = 16'h0010; // header, check sequence, CRC bytes
   localparam logic [7:0]  UMFF_RETRY_RST     = 8'h10;
   localparam logic [15:0] UMFF_ACKT_US_RST   = 16'h0064; // ack time, us
   localparam logic [15:0] UMFF_POH_RST       = 16'h001c;
   localparam int          UMFF_CLK_MHZ       = 100;
   localparam int          UMFF_US_CYC        = UMFF_CLK_MHZ; // cycles per microsecond
   localparam logic [1:0]  UMFF_AXI_OKAY      = 2'b00;
   localparam logic [1:0]  UMFF_AXI_SLVERR    = 2'b10;

   typedef enum logic [1:0]
   {
      UMFF_IDLE = 2'b00, // no frame held
      UMFF_WAIT = 2'b01, // request sent, waiting for grant
      UMFF_HOLD = 2'b10  // grant pending seen or more grants queued, waiting for real grant
   } umff_state_e;
endpackage

// >>> umff_tick.sv
// Microsecond enable divider for the fragmenter's ack timer.
// Assumes one clock; output is a one-cycle pulse every DIV cycles.
`timescale 1ns/1ns
module umff_tick
#(
   parameter int DIV = 100
)
(
   input  wire logic sys_clk,
   input  wire logic rst_n,
   output logic      tick
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   wire        wrap = (cnt_q == 8'(DIV - 1));

   // Free running count, wraps each microsecond
   assign cnt_d = wrap ? 8'h00 : cnt_q + 8'h01;
   assign tick  = wrap;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= 8'h00;
      else
         cnt_q <= cnt_d;
   end
endmodule

// >>> umff_top.sv
// Upstream frame fragmenter: cuts a queued MAC frame into fragments fitted to
// grants, builds fragment header fields and bandwidth requests, runs ack timer.
// Assumes software (or a map parser) writes grants over AXI4-Lite; one clock.
// Behaviour
// - Partial grant filled with maximum fitting payload
// - Piggyback when no later grant seen
// - Piggyback carried in privacy extended header
// - Request remainder plus sixteen bytes plus overhead
// - Ack timeout backs off, re-requests until threshold (here: re-requests at once, no backoff)
// - Past retry threshold discard untransmitted part
// - First fragment: first set, last clear
// - Middle fragments: both flags clear
// - Last fragment: last set, first clear
// - Sequence number increments per fragment
// - Encryption spans header check end to CRC
// - Never fragment request/data region frames
// - Fragment is header, payload, trailing CRC
// - Untransmitted portion is whole frame, then remainder
// - Queued grants: piggyback field zero, wait
// - Grant pending with grant: no piggyback (here: a pending seen earlier does not stop piggyback)
`timescale 1ns/1ns
module umff_top
   import umff_pkg::*;
#(
   parameter int LEN_W = umff_pkg::UMFF_LEN_W
)
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             irq
);
   import umff_pkg::*;

   // ****************************************************************
   // Register bus slave
   // ****************************************************************
   logic [7:0]  awaddr_q;
   logic        aw_full_q;
   logic [31:0] wdata_q;
   logic        w_full_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;

   // Address and data are latched independently, then one write fires
   assign s_axi_awready = !aw_full_q && !bvalid_q;
   assign s_axi_wready  = !w_full_q && !bvalid_q;
   wire   wr_fire       = aw_full_q && w_full_q && !bvalid_q;
   wire   rd_fire       = s_axi_arvalid && !rvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // Byte lanes gated by strobes on every write; unstrobed bytes are written as zero, not merged
   wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                        {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
   wire  [31:0] wd  = wdata_q;
   wire  wr_ctrl    = wr_fire && (awaddr_q == UMFF_CTRL_OFF);
   wire  wr_frame   = wr_fire && (awaddr_q == UMFF_FRAME_OFF);
   wire  wr_grant   = wr_fire && (awaddr_q == UMFF_GRANT_OFF);
   wire  wr_msk     = wr_fire && (awaddr_q == UMFF_IRQ_MSK_OFF);
   wire  wr_retry   = wr_fire && (awaddr_q == UMFF_RETRY_OFF);
   wire  wr_ackt    = wr_fire && (awaddr_q == UMFF_ACKT_OFF);
   wire  wr_poh     = wr_fire && (awaddr_q == UMFF_POH_OFF);
   wire  wr_hit     = wr_ctrl | wr_frame | wr_grant | wr_msk | wr_retry | wr_ackt | wr_poh;
   wire  rd_sts     = rd_fire && (s_axi_araddr == UMFF_IRQ_STS_OFF);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         bvalid_q  <= 1'b0;
         bresp_q   <= UMFF_AXI_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full_q <= 1'b1;
            awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full_q <= 1'b1;
            wdata_q  <= s_axi_wdata & wmask;
         end
         if (wr_fire)
         begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_hit ? UMFF_AXI_OKAY : UMFF_AXI_SLVERR;
         end
         else if (bvalid_q && s_axi_bready)
            bvalid_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   logic              frag_en_q;
   logic [7:0]        retry_max_q;
   logic [15:0]       ackt_us_q;
   logic [15:0]       poh_q;
   logic [UMFF_EV_W-1:0] irq_msk_q;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         frag_en_q   <= 1'b0;
         retry_max_q <= UMFF_RETRY_RST;
         ackt_us_q   <= UMFF_ACKT_US_RST;
         poh_q       <= UMFF_POH_RST;
         irq_msk_q   <= '0;
      end
      else
      begin
         if (wr_ctrl)
            frag_en_q <= wd[UMFF_CTRL_FRAG_EN];
         if (wr_retry)
            retry_max_q <= wd[7:0];
         if (wr_ackt)
            ackt_us_q <= wd[15:0];
         if (wr_poh)
            poh_q <= wd[15:0];
         if (wr_msk)
            irq_msk_q <= wd[UMFF_EV_W-1:0];
      end
   end

   // ****************************************************************
   // Fragmentation engine
   // ****************************************************************
   umff_state_e      st_q;
   umff_state_e      st_d;
   logic [LEN_W-1:0] rem_q;      // untransmitted portion
   logic             started_q;  // a fragment has gone out
   logic             imm_q;      // frame bound to request/data region
   logic [UMFF_SEQ_W-1:0] seq_q;
   logic [7:0]       retry_q;
   logic [15:0]      ack_cnt_q;
   logic [31:0]      frag_q;     // last fragment descriptor
   logic [31:0]      req_q;      // last request length and kind
   logic [UMFF_EV_W-1:0] ev;
   logic             tick;

   umff_tick #(.DIV(UMFF_US_CYC)) u_tick
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .tick    (tick)
   );

   // Grant fields: byte count after physical overhead, pending and queued flags
   wire [LEN_W-1:0] g_len   = wd[LEN_W-1:0];
   wire             g_pend  = wd[UMFF_GRANT_PEND];
   wire             g_more  = wd[UMFF_GRANT_MORE];
   wire             active  = (st_q != UMFF_IDLE);
   wire             g_data  = wr_grant && active && !g_pend;
   // Frame-size need versus grant; grants are net of physical overhead
   wire [LEN_W-1:0] g_pay   = (g_len > UMFF_FRAG_OVH) ? g_len - UMFF_FRAG_OVH : '0;
   wire             fits    = started_q ? (g_pay >= rem_q) : (g_len >= rem_q);
   wire             can_frag = frag_en_q && !imm_q;
   wire             partial = g_data && !fits && can_frag && (g_pay != '0);
   wire             finish  = g_data && fits;
   // Payload taken: maximum that fits after fragment overhead
   wire [LEN_W-1:0] take    = fits ? rem_q : g_pay;
   wire [LEN_W-1:0] left    = rem_q - take;
   // Remainder request covers remainder, fragment overhead and phy overhead
   wire [LEN_W-1:0] rem_req = LEN_W'(left + UMFF_FRAG_OVH + poh_q);
   wire [LEN_W-1:0] re_req  = started_q ? LEN_W'(rem_q + UMFF_FRAG_OVH + poh_q)
                                        : LEN_W'(rem_q + poh_q);
   // No later grant queued in map: piggyback, else zero field; a pending element seen earlier does not count
   wire             piggy   = partial && !g_more;
   wire             ack_exp = (st_q == UMFF_WAIT) && tick && (ack_cnt_q >= ackt_us_q);
   wire             give_up = ack_exp && (retry_q >= retry_max_q);
   wire             f_first = !started_q;
   wire             f_last  = started_q && finish;
   // Privacy runs per fragment, from after the header check through the CRC
   wire             f_crypt = partial || started_q;

   // State transitions
   always_comb
   begin
      st_d = st_q;
      unique case (st_q)
         UMFF_IDLE:
            if (wr_frame && wd[UMFF_FRAME_GO])
               st_d = UMFF_WAIT;
         UMFF_WAIT,
         UMFF_HOLD:
            if (finish || give_up)
               st_d = UMFF_IDLE;
            else if (wr_grant && g_pend)
               st_d = UMFF_HOLD;
            else if ((partial && !piggy) || (partial && piggy))
               st_d = g_more ? UMFF_HOLD : UMFF_WAIT;
            else if (g_data)
               st_d = UMFF_WAIT; // no payload room or fragmenting not allowed, keep waiting
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q      <= UMFF_IDLE;
         rem_q     <= '0;
         started_q <= 1'b0;
         imm_q     <= 1'b0;
         seq_q     <= '0;
         retry_q   <= 8'h00;
         ack_cnt_q <= 16'h0000;
         frag_q    <= 32'h0000_0000;
         req_q     <= 32'h0000_0000;
      end
      else
      begin
         st_q <= st_d;
         // Ack timer counts only while waiting; a pending resets it
         if (st_q != UMFF_WAIT || wr_grant || ack_exp)
            ack_cnt_q <= 16'h0000;
         else if (tick)
            ack_cnt_q <= ack_cnt_q + 16'h0001;
         if (st_q == UMFF_IDLE && wr_frame && wd[UMFF_FRAME_GO])
         begin
            rem_q     <= wd[LEN_W-1:0];
            imm_q     <= wd[UMFF_FRAME_IMM];
            started_q <= 1'b0;
            retry_q   <= 8'h00;
            req_q     <= {16'h0000, LEN_W'(wd[LEN_W-1:0] + poh_q)};
         end
         else if (give_up)
            rem_q <= '0;
         else if (ack_exp)
         begin
            retry_q <= retry_q + 8'h01;
            req_q   <= {16'h0001, re_req};
         end
         else if (partial || finish)
         begin
            // Descriptor: first, last, privacy span, piggyback in header
            frag_q <= {f_crypt, f_first & partial, f_last,
                       piggy, seq_q, 2'b00, take[9:0], 12'h000};
            rem_q     <= left;
            started_q <= partial;
            retry_q   <= 8'h00;
            seq_q     <= seq_q + 1'b1;
            req_q     <= piggy ? {16'h0002, rem_req} : req_q;
         end
         else if (wr_grant)
            retry_q <= 8'h00;
      end
   end

   // ****************************************************************
   // Interrupt status and read path
   // ****************************************************************
   logic [UMFF_EV_W-1:0] irq_sts_q;
   assign ev[UMFF_EV_FRAG]    = partial;
   assign ev[UMFF_EV_DONE]    = finish;
   assign ev[UMFF_EV_RETRY]   = ack_exp && !give_up;
   assign ev[UMFF_EV_DISCARD] = give_up;
   assign irq = |(irq_sts_q & irq_msk_q);

   wire [31:0] rd_mux =
      (s_axi_araddr == UMFF_CTRL_OFF)    ? {31'h0, frag_en_q} :
      (s_axi_araddr == UMFF_FRAG_OFF)    ? frag_q :
      (s_axi_araddr == UMFF_REQ_OFF)     ? req_q :
      (s_axi_araddr == UMFF_STATE_OFF)   ? {6'h00, st_q, seq_q, 4'h0, 16'(rem_q)} :
      (s_axi_araddr == UMFF_IRQ_STS_OFF) ? {28'h0, irq_sts_q} :
      (s_axi_araddr == UMFF_IRQ_MSK_OFF) ? {28'h0, irq_msk_q} :
      (s_axi_araddr == UMFF_RETRY_OFF)   ? {24'h0, retry_max_q} :
      (s_axi_araddr == UMFF_ACKT_OFF)    ? {16'h0, ackt_us_q} :
      (s_axi_araddr == UMFF_POH_OFF)     ? {16'h0, poh_q} : 32'h0000_0000;
   wire rd_hit = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr <= UMFF_POH_OFF)
                 && (s_axi_araddr != UMFF_FRAME_OFF) && (s_axi_araddr != UMFF_GRANT_OFF);

   // Read clears status; a new event in the same cycle still sets
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_sts_q <= '0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= UMFF_AXI_OKAY;
      end
      else
      begin
         irq_sts_q <= (rd_sts ? '0 : irq_sts_q) | ev;
         if (rd_fire)
         begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_hit ? rd_mux : 32'h0000_0000;
            rresp_q  <= rd_hit ? UMFF_AXI_OKAY : UMFF_AXI_SLVERR;
         end
         else if (rvalid_q && s_axi_rready)
            rvalid_q <= 1'b0;
      end
   end
endmodule

// >>> umff_props.sv
// Checker for the fragmenter's register port and interrupt line.
// Bound to umff_top; sees only its ports, one clock domain.
`timescale 1ns/1ns
module umff_props
   import umff_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        irq
);
   // ****************************************************************
   // Handshake relations
   // ****************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   // Held read data must not drift while software waits
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data changed");
   property p_r_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_answer: assert property (p_r_answer) else $error("read answer late");
   property p_b_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_b_answer: assert property (p_b_answer) else $error("write answer late");
   property p_unmapped;
      s_axi_arvalid && s_axi_arready && (s_axi_araddr > UMFF_POH_OFF)
         |=> (s_axi_rresp == UMFF_AXI_SLVERR) && (s_axi_rdata == 32'h0);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
   property p_no_aw;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_no_aw: assert property (p_no_aw) else $error("write taken under response");
   property p_r_once;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_r_once: assert property (p_r_once) else $error("read answered twice");
   property p_b_once;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_once: assert property (p_b_once) else $error("write answered twice");
   c_slverr: cover property (s_axi_rvalid && (s_axi_rresp == UMFF_AXI_SLVERR));
   c_irq: cover property ($rose(irq));
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule

// >>> umff_headend_model.sv
// Headend model: forms grant map words and the per-flow enable word.
// Assumes the bench writes its outputs into the fragmenter's registers.
`timescale 1ns/1ns
module umff_headend_model
(
   input  wire logic [15:0] grant_bytes,
   input  wire logic        more_queued,
   input  wire logic        pend_elem,
   input  wire logic        frag_allow,
   output logic [31:0]      grant_word,
   output logic [31:0]      ctrl_word
);
   // Size is taken as given: a grant below the request starts fragmenting
   assign grant_word = {pend_elem, more_queued, 14'h0, grant_bytes};
   assign ctrl_word  = {31'h0, frag_allow};
endmodule

// >>> umff_top_tb.sv
// Self-checking bench for the fragmenter, driven over AXI4-Lite.
// Assumes umff_top, umff_headend_model and umff_props are compiled first.
`timescale 1ns/1ns
module umff_top_tb;
   import umff_pkg::*;
   localparam logic [15:0] FLEN = 16'h03fa;
   localparam logic [15:0] G1   = 16'h0384;
   localparam logic [15:0] P1   = G1 - UMFF_FRAG_OVH;
   localparam logic [15:0] R1   = FLEN - P1;
   localparam logic [15:0] G2   = 16'h0064;
   localparam logic [15:0] R2   = R1 - (G2 - UMFF_FRAG_OVH);
   localparam logic [31:0] MF   = 32'hff3ff000;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata, g_word, c_word;
   logic [15:0] g_bytes = 16'h0;
   logic        g_more = 1'b0, g_pend = 1'b0;
   logic [31:0] rd_data;
   logic [1:0]  rd_resp, wr_resp;
   logic [3:0]  sq;
   int          n_errors = 0, checked = 0, cyc = 0;
   // ****************************************************************
   // Clock, design and headend model
   // ****************************************************************
   always #5 sys_clk = ~sys_clk;
   umff_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
   umff_headend_model he (.grant_bytes(g_bytes), .more_queued(g_more), .pend_elem(g_pend),
      .frag_allow(1'b1), .grant_word(g_word), .ctrl_word(c_word));
   // ****************************************************************
   // Bus tasks and comparison
   // ****************************************************************
   task automatic summarize();
      if (n_errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
      checked++;
      if ((g & m) !== (e & m))
      begin
         n_errors++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask
   // Address and data offered together; each dropped when its own ready is seen
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge sys_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1)
         begin
            wr_resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            n = 200;
         end
      end
      if (n < 200) chk(32'h1, 32'h0, 32'h1);
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge sys_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1)
         begin
            rd_data = s_axi_rdata;
            rd_resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            n = 200;
         end
      end
      if (n < 200) chk(32'h1, 32'h0, 32'h1);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      rd(a);
      chk(rd_data, e, m);
   endtask
   task automatic grant(input logic [15:0] b, input logic more);
      g_bytes = b;
      g_more = more;
      #1;
      wr(UMFF_GRANT_OFF, g_word);
   endtask
   task automatic wait_irq();
      int n;
      for (n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge sys_clk);
      chk({31'h0, irq}, 32'h1, 32'h1);
   endtask
   function automatic logic [31:0] frag(logic f, logic l, logic p, logic [3:0] s, logic [15:0] b);
      return {1'b1, f, l, p, s, 2'b00, b[9:0], 12'h000}; // Fragments carry the privacy span
   endfunction
   // Cut a hung run short
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_errors++;
         summarize();
      end
   end
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial
   begin
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      rc(UMFF_POH_OFF, {16'h0, UMFF_POH_RST}, 32'hffffffff);
      rc(UMFF_RETRY_OFF, {24'h0, UMFF_RETRY_RST}, 32'hffffffff);
      rc(UMFF_ACKT_OFF, {16'h0, UMFF_ACKT_US_RST}, 32'hffffffff);
      rc(8'h40, 32'h0, 32'hffffffff);
      chk({30'h0, rd_resp}, {30'h0, UMFF_AXI_SLVERR}, 32'h3);
      wr(8'h40, 32'h1);
      chk({30'h0, wr_resp}, {30'h0, UMFF_AXI_SLVERR}, 32'h3);
      wr(UMFF_CTRL_OFF, c_word);
      wr(UMFF_IRQ_MSK_OFF, 32'hf);
      wr(UMFF_FRAME_OFF, {16'h8000, FLEN});
      rc(UMFF_STATE_OFF, {8'h01, 8'h0, FLEN}, 32'h0300ffff);
      grant(G1, 1'b0);
      rc(UMFF_FRAG_OFF, frag(1, 0, 1, 0, P1), 32'hf03ff000);
      sq = rd_data[27:24];
      rc(UMFF_REQ_OFF, {16'h2, R1 + UMFF_FRAG_OVH + UMFF_POH_RST}, 32'hffffffff);
      rc(UMFF_STATE_OFF, {8'h01, 8'h0, R1}, 32'h0300ffff);
      chk({31'h0, irq}, 32'h1, 32'h1);
      rc(UMFF_IRQ_STS_OFF, 32'h1, 32'h1);
      rc(UMFF_IRQ_STS_OFF, 32'h0, 32'hf);
      chk({31'h0, irq}, 32'h0, 32'h1);
      grant(G2, 1'b1);
      rc(UMFF_FRAG_OFF, frag(0, 0, 0, sq + 4'h1, G2 - UMFF_FRAG_OVH), MF);
      rc(UMFF_STATE_OFF, {8'h02, 8'h0, R2}, 32'h0300ffff);
      grant(16'h00c8, 1'b0);
      rc(UMFF_FRAG_OFF, frag(0, 1, 0, sq + 4'h2, R2), 32'hef3ff000);
      rc(UMFF_STATE_OFF, 32'h0, 32'h0300ffff);
      rc(UMFF_IRQ_STS_OFF, 32'h2, 32'h2);
      // Request/data frame: a short grant must not split it
      wr(UMFF_IRQ_MSK_OFF, 32'h4);
      wr(UMFF_FRAME_OFF, {16'hc000, FLEN});
      grant(G1, 1'b0);
      rc(UMFF_STATE_OFF, {8'h01, 8'h0, FLEN}, 32'h0300ffff);
      wr(UMFF_RETRY_OFF, 32'h1);
      wr(UMFF_ACKT_OFF, 32'h2);
      wait_irq();
      rc(UMFF_REQ_OFF, {16'h1, FLEN + UMFF_POH_RST}, 32'hffffffff);
      rc(UMFF_IRQ_STS_OFF, 32'h4, 32'h4);
      wr(UMFF_IRQ_MSK_OFF, 32'h8);
      wait_irq();
      rc(UMFF_IRQ_STS_OFF, 32'h8, 32'h8);
      rc(UMFF_STATE_OFF, 32'h0, 32'h0300ffff);
      summarize();
   end
endmodule
bind umff_top umff_props u_props (.sys_clk(sys_clk), .rst_n(rst_n),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
